// >>> core/universal_input_conditioner.v
// eight-channel universal input conditioner with wishbone settings port
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`include "uic_map.vh"
module universal_input_conditioner (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire [31:0] adr_i,
    input  wire [31:0] dat_i,
    input  wire [3:0]  sel_i,
    input  wire        we_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // terminal sampler
    input  wire        sample_valid_i,
    input  wire [2:0]  sample_ch_i,
    input  wire [15:0] sample_mv_i,
    output reg         sample_ready_o,
    // parameter network
    output reg         par_wr_o,
    output reg  [9:0]  par_idx_o,
    output reg  [15:0] par_val_o,
    output reg         par_level_o,
    // fixed internal path of terminal 3
    output reg         fast_ref_wr_o,
    output reg  [15:0] fast_ref_o,
    // comparator states, bit 0 is terminal 2
    output reg  [7:0]  logic_state_o
);
    localparam [5:0] S_INIT = 6'h01;
    localparam [5:0] S_IDLE = 6'h02;
    localparam [5:0] S_BUS  = 6'h04;
    localparam [5:0] S_LOAD = 6'h08;
    localparam [5:0] S_CALC = 6'h10;
    localparam [5:0] S_EMIT = 6'h20;

    reg  [5:0]  state_q;
    reg  [5:0]  state_d;
    reg  [6:0]  init_q;
    reg  [3:0]  cnt_q;
    reg  [1:0]  slot_q;
    reg  [2:0]  ch_q;
    reg  [15:0] volt_q;
    reg  [15:0] cfg_q [0:12];
    reg  [15:0] lin_q;
    reg  [15:0] val1_q;
    reg  [15:0] val2_q;
    reg  [7:0]  bus_idx_q;
    reg         bus_map_q;
    reg         mem_we;
    reg  [6:0]  mem_addr;
    reg  [15:0] mem_wdata;
    reg  [9:0]  dest;
    reg  [15:0] value;
    wire [15:0] mem_rdata;
    wire [15:0] lin_w;
    wire        cmp_w;
    wire [15:0] val1_w;
    wire [15:0] val2_w;
    wire        bus_req;
    wire        take_sample;
    wire [7:0]  word_idx;
    wire        cfg_hit;
    integer     i;

    // reset content of one settings word
    function [15:0] default_of;
        input [2:0] ch;
        input [3:0] fld;
        begin
            default_of = 16'h0000;
            case (fld)
                `F_RANGE:   default_of = {14'h0000, `RANGE_RST};
                `F_SCALE:   default_of = `SCALE_RST;
                `F_CLMAX:   default_of = `CLMAX_RST;
                `F_CLMIN:   default_of = `CLMIN_RST;
                `F_HI1:     default_of = `HI_RST;
                `F_LO1:     default_of = `LO_RST;
                `F_HI2:     default_of = `HI_RST;
                `F_LO2:     default_of = `LO_RST;
                `F_THRESH:  default_of = `THRESH_RST;
                `F_DEST_LIN:
                begin
                    case (ch)
                        3'h0:    default_of = {6'h00, `DEST_CH2};
                        3'h2:    default_of = {6'h00, `DEST_CH4};
                        3'h3:    default_of = {6'h00, `DEST_CH5};
                        3'h4:    default_of = {6'h00, `DEST_CH6};
                        default: default_of = {6'h00, `DEST_NONE};
                    endcase
                end
                `F_DEST1:
                begin
                    case (ch)
                        3'h5:    default_of = {6'h00, `DEST_CH7};
                        3'h6:    default_of = {6'h00, `DEST_CH8};
                        3'h7:    default_of = {6'h00, `DEST_CH9};
                        default: default_of = {6'h00, `DEST_NONE};
                    endcase
                end
                `F_DEST2:   default_of = {6'h00, `DEST_NONE};
                default:    default_of = 16'h0000;
            endcase
        end
    endfunction

    // signed limit to +/- lim
    function [15:0] limit;
        input [15:0] v;
        input [15:0] lim;
        begin
            if ($signed(v) > $signed(lim))
            begin
                limit = lim;
            end
            else if ($signed(v) < -$signed(lim))
            begin
                limit = 16'h0000 - lim;
            end
            else
            begin
                limit = v;
            end
        end
    endfunction

    // write data as stored: out-of-range values saturate instead of being refused, except range, which keeps only its low two bits
    function [15:0] condition;
        input [3:0]  fld;
        input [15:0] d;
        begin
            case (fld)
                `F_RANGE:    condition = {14'h0000, d[1:0]};
                `F_OFFSET:   condition = limit(d, `OFS_LIM);
                `F_DEST_LIN,
                `F_DEST1,
                `F_DEST2:    condition = (d[15:10] != 6'h00 || d[9:0] > `DEST_MAX) ?
                                         {6'h00, `DEST_MAX} : d;
                default:     condition = limit(d, `VAL_LIM);
            endcase
        end
    endfunction

    assign word_idx    = adr_i[9:2];
    assign cfg_hit     = (adr_i[31:10] == 22'h000000) && (word_idx < `CFG_WORDS) &&
                         (word_idx[3:0] < `F_COUNT);
    assign bus_req     = cyc_i && stb_i && !ack_o;
    assign take_sample = sample_valid_i && sample_ready_o;

    uic_cfg_mem cfg_mem (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (mem_wdata),
        .rdata_q (mem_rdata)
    );

    // the settings of the latched channel feed one shared datapath
    uic_datapath datapath (
        .volt_i   (volt_q),
        .range_i  (cfg_q[`F_RANGE][1:0]),
        .offset_i (cfg_q[`F_OFFSET]),
        .scale_i  (cfg_q[`F_SCALE]),
        .clmax_i  (cfg_q[`F_CLMAX]),
        .clmin_i  (cfg_q[`F_CLMIN]),
        .thresh_i (cfg_q[`F_THRESH]),
        .hi1_i    (cfg_q[`F_HI1]),
        .lo1_i    (cfg_q[`F_LO1]),
        .hi2_i    (cfg_q[`F_HI2]),
        .lo2_i    (cfg_q[`F_LO2]),
        .lin_o    (lin_w),
        .cmp_o    (cmp_w),
        .val1_o   (val1_w),
        .val2_o   (val2_w)
    );

    // memory port: init sweep, bus access or channel load share one port
    always @*
    begin
        mem_we    = 1'b0;
        mem_addr  = 7'h00;
        mem_wdata = 16'h0000;
        case (state_q)
            S_INIT:
            begin
                mem_we    = 1'b1;
                mem_addr  = init_q;
                mem_wdata = default_of(init_q[6:4], init_q[3:0]);
            end
            S_IDLE:
            begin
                mem_addr  = word_idx[6:0];
                mem_wdata = condition(word_idx[3:0], dat_i[15:0]);
                mem_we    = !take_sample && bus_req && we_i && cfg_hit && sel_i[0] && sel_i[1];
            end
            S_LOAD:
            begin
                mem_addr = {ch_q, cnt_q};
            end
            default:
            begin
                mem_addr = 7'h00;
            end
        endcase
    end

    always @*
    begin
        state_d = state_q;
        case (state_q)
            S_INIT:
            begin
                if (init_q == 7'h7f)
                begin
                    state_d = S_IDLE;
                end
            end
            S_IDLE:
            begin
                if (take_sample)
                begin
                    state_d = S_LOAD;
                end
                else if (bus_req)
                begin
                    state_d = S_BUS;
                end
            end
            S_BUS:   state_d = S_IDLE;
            S_LOAD:
            begin
                if (cnt_q == `F_COUNT)
                begin
                    state_d = S_CALC;
                end
            end
            S_CALC:  state_d = S_EMIT;
            S_EMIT:
            begin
                if (slot_q == 2'h2)
                begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_INIT;
        endcase
    end

    // destination and value of the current emit slot
    always @*
    begin
        case (slot_q)
            2'h1:
            begin
                dest  = cfg_q[`F_DEST1][9:0];
                value = val1_q;
            end
            2'h2:
            begin
                dest  = cfg_q[`F_DEST2][9:0];
                value = val2_q;
            end
            default:
            begin
                dest  = cfg_q[`F_DEST_LIN][9:0];
                value = lin_q;
            end
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q        <= S_INIT;
            init_q         <= 7'h00;
            cnt_q          <= 4'h0;
            slot_q         <= 2'h0;
            ch_q           <= 3'h0;
            volt_q         <= 16'h0000;
            lin_q          <= 16'h0000;
            val1_q         <= 16'h0000;
            val2_q         <= 16'h0000;
            bus_idx_q      <= 8'h00;
            bus_map_q      <= 1'b0;
            dat_o          <= 32'h00000000;
            ack_o          <= 1'b0;
            sample_ready_o <= 1'b0;
            par_wr_o       <= 1'b0;
            par_idx_o      <= 10'h000;
            par_val_o      <= 16'h0000;
            par_level_o    <= 1'b0;
            fast_ref_wr_o  <= 1'b0;
            fast_ref_o     <= 16'h0000;
            logic_state_o  <= 8'h00;
            for (i = 0; i < 13; i = i + 1)
            begin
                cfg_q[i] <= 16'h0000;
            end
        end
        else
        begin
            state_q        <= state_d;
            ack_o          <= 1'b0;
            par_wr_o       <= 1'b0;
            fast_ref_wr_o  <= 1'b0;
            // a new sample is accepted only from the idle state
            sample_ready_o <= (state_d == S_IDLE);
            case (state_q)
                S_INIT:
                begin
                    init_q <= init_q + 7'h01;
                end
                S_IDLE:
                begin
                    cnt_q  <= 4'h0;
                    slot_q <= 2'h0;
                    if (take_sample)
                    begin
                        ch_q   <= sample_ch_i;
                        volt_q <= sample_mv_i;
                    end
                    else if (bus_req)
                    begin
                        bus_idx_q <= word_idx;
                        bus_map_q <= cfg_hit;
                    end
                end
                S_BUS:
                begin
                    ack_o <= 1'b1;
                    if (bus_map_q)
                    begin
                        dat_o <= {16'h0000, mem_rdata};
                    end
                    else if (bus_idx_q == `IDX_STATUS && adr_i[31:10] == 22'h000000)
                    begin
                        dat_o <= {24'h000000, logic_state_o};
                    end
                    else
                    begin
                        dat_o <= 32'h00000000;
                    end
                end
                S_LOAD:
                begin
                    // read data trails the address by one cycle
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q != 4'h0)
                    begin
                        cfg_q[cnt_q - 4'h1] <= mem_rdata;
                    end
                end
                S_CALC:
                begin
                    lin_q                <= lin_w;
                    val1_q               <= val1_w;
                    val2_q               <= val2_w;
                    logic_state_o[ch_q]  <= cmp_w;
                end
                S_EMIT:
                begin
                    slot_q      <= slot_q + 2'h1;
                    par_wr_o    <= (dest != `DEST_NONE);
                    par_idx_o   <= dest;
                    par_val_o   <= value;
                    par_level_o <= (value != 16'h0000);
                    if (slot_q == 2'h0 && ch_q == `TERM3_CH)
                    begin
                        fast_ref_wr_o <= 1'b1;
                        fast_ref_o    <= lin_q;
                    end
                end
                default:
                begin
                    cnt_q <= 4'h0;
                end
            endcase
        end
    end
endmodule

// >>> pkg/uic_map.vh
// register map, field layout and reset values of the universal input conditioner
// How it works
// - eight identical channels, terminals 2 to 9, each with its own settings
// - per-channel input range 5, 10, 20 or 30 volts, 10 volts after reset
// - offset unit is fixed: 100 percent equals 10 volts on every range
// - offset is added to the terminal reading before scaling
// - comparator sees the reading before the offset is added
// - comparator sees the unscaled reading, scaling never touches it
// - factor 1.0000 maps full range input to 100.00 percent
// - signed factor, negative factor inverts the linear output
// - scaled output held between per-channel minimum and maximum clamp
// - comparator high only when input strictly above threshold
// - threshold compare is signed and algebraic
// - linear destination accepts indexes 000 to 720
// - two logic outputs per channel, each with own destination 000 to 720
// - each logic output has its own high and low value
// - high value of logic output 1 limited to 300.00 percent, resets to 0.01
// - logic output 2 destination resets to 400 on every channel
// - linear destinations reset to 63, 400, 26, 90, 89, 400, 400, 400
// - channel 3 linear feeds a fixed internal port, selector resets to 400
// - logic output 1 destinations reset to 52, 48, 49 on channels 7 to 9
// - comparator high drives high values, low drives low values
// - destination 400 means disconnected, no parameter is written
// - zero value is logic low, any nonzero signed value is logic high
`ifndef UIC_MAP_VH
`define UIC_MAP_VH

// word index = {channel[2:0], field[3:0]}, byte address = 4 * index
`define F_RANGE     4'h0
`define F_OFFSET    4'h1
`define F_SCALE     4'h2
`define F_CLMAX     4'h3
`define F_CLMIN     4'h4
`define F_HI1       4'h5
`define F_LO1       4'h6
`define F_HI2       4'h7
`define F_LO2       4'h8
`define F_THRESH    4'h9
`define F_DEST_LIN  4'ha
`define F_DEST1     4'hb
`define F_DEST2     4'hc
`define F_COUNT     4'hd
`define IDX_STATUS  8'h80
`define CFG_WORDS   8'h80

// range codes and full scale in millivolts
`define RANGE_5V    2'h0
`define RANGE_10V   2'h1
`define RANGE_20V   2'h2
`define RANGE_30V   2'h3
`define MV_5V       40'sh0000001388
`define MV_10V      40'sh0000002710
`define MV_20V      40'sh0000004e20
`define MV_30V      40'sh0000007530

// value limits, 0.01 percent or 1 mV per lsb
`define OFS_LIM     16'h2710
`define VAL_LIM     16'h7530
`define DEST_NONE   10'h190
`define DEST_MAX    10'h2d0
`define TERM3_CH    3'h1

// reset values
`define RANGE_RST   2'h1
`define SCALE_RST   16'h2710
`define CLMAX_RST   16'h2710
`define CLMIN_RST   16'hd8f0
`define HI_RST      16'h0001
`define LO_RST      16'h0000
`define THRESH_RST  16'h0000
`define DEST_CH2    10'h03f
`define DEST_CH4    10'h01a
`define DEST_CH5    10'h05a
`define DEST_CH6    10'h059
`define DEST_CH7    10'h034
`define DEST_CH8    10'h030
`define DEST_CH9    10'h031

`endif

// >>> core/uic_cfg_mem.v
// settings memory for all eight channels, registered read
`timescale 1ns/1ns
module uic_cfg_mem (
    // clock
    input  wire        clk_i,
    // single port
    input  wire        we_i,
    input  wire [6:0]  addr_i,
    input  wire [15:0] wdata_i,
    output reg  [15:0] rdata_q
);
    reg [15:0] mem [0:127];

    always @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= wdata_i;
        end
        rdata_q <= mem[addr_i];
    end
endmodule

// >>> core/uic_datapath.v
// combinational linear and logic path of one channel sample
`timescale 1ns/1ns
`include "uic_map.vh"
module uic_datapath (
    // terminal reading, mV
    input  wire signed [15:0] volt_i,
    // settings
    input  wire        [1:0]  range_i,
    input  wire signed [15:0] offset_i,
    input  wire signed [15:0] scale_i,
    input  wire signed [15:0] clmax_i,
    input  wire signed [15:0] clmin_i,
    input  wire signed [15:0] thresh_i,
    input  wire signed [15:0] hi1_i,
    input  wire signed [15:0] lo1_i,
    input  wire signed [15:0] hi2_i,
    input  wire signed [15:0] lo2_i,
    // results
    output wire signed [15:0] lin_o,
    output wire               cmp_o,
    output wire signed [15:0] val1_o,
    output wire signed [15:0] val2_o
);
    reg signed [39:0] full_mv;
    wire signed [39:0] summed;
    wire signed [39:0] product;
    wire signed [39:0] scaled;

    always @*
    begin
        case (range_i)
            `RANGE_5V:  full_mv = `MV_5V;
            `RANGE_20V: full_mv = `MV_20V;
            `RANGE_30V: full_mv = `MV_30V;
            default:    full_mv = `MV_10V;
        endcase
    end

    // offset lsb is 1 mV on every range, so it adds straight to the reading
    assign summed  = {{24{volt_i[15]}}, volt_i} + {{24{offset_i[15]}}, offset_i};
    // 1.0000 is 10000 counts and 100.00 % is 10000 counts: out = sum * scale / full
    assign product = summed * {{24{scale_i[15]}}, scale_i};
    assign scaled  = product / full_mv;

    // clamps never exceed 16 bits, so the clamped value fits after the cut
    assign lin_o = (scaled > $signed({{24{clmax_i[15]}}, clmax_i})) ? clmax_i :
                   (scaled < $signed({{24{clmin_i[15]}}, clmin_i})) ? clmin_i : scaled[15:0];

    // raw terminal value only: no offset, no scaling
    assign cmp_o  = (volt_i > thresh_i);
    assign val1_o = cmp_o ? hi1_i : lo1_i;
    assign val2_o = cmp_o ? hi2_i : lo2_i;
endmodule

// >>> verif/uic_props.sv
// port-level assertions for the universal input conditioner
`timescale 1ns/1ns
module uic_props (
    // clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // wishbone
    input wire        cyc_i,
    input wire        stb_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    // sampler
    input wire        sample_valid_i,
    input wire        sample_ready_o,
    // parameter network
    input wire        par_wr_o,
    input wire [9:0]  par_idx_o,
    input wire [15:0] par_val_o,
    input wire        par_level_o,
    input wire        fast_ref_wr_o,
    input wire [7:0]  logic_state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    chk_read_upper: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    chk_no_disconnect: assert property (par_wr_o |-> par_idx_o != 10'h190)
        else $error("write issued to the disconnect index");
    chk_dest_range: assert property (par_wr_o |-> par_idx_o <= 10'h2d0)
        else $error("write index above the top of the range");
    chk_level_map: assert property (par_wr_o |-> par_level_o == (par_val_o != 16'h0000))
        else $error("logic level does not follow value");
    chk_busy_hold: assert property (sample_valid_i && sample_ready_o |=> !sample_ready_o [*8])
        else $error("ready returned too early after a sample");
    chk_emit_busy: assert property ((par_wr_o || fast_ref_wr_o) |-> !$past(sample_ready_o))
        else $error("result emitted outside sample processing");
    chk_state_busy: assert property (!$past(rst_i) && !$stable(logic_state_o) |-> !$past(sample_ready_o))
        else $error("comparator state changed while idle");
endmodule

bind universal_input_conditioner uic_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .par_wr_o(par_wr_o),
    .par_idx_o(par_idx_o), .par_val_o(par_val_o), .par_level_o(par_level_o),
    .fast_ref_wr_o(fast_ref_wr_o), .logic_state_o(logic_state_o)
);

// >>> verif/sampler_model.sv
// terminal sampler model offering one reading at a time
`timescale 1ns/1ns
module sampler_model (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // bench request
    input  wire        go_i,
    input  wire [2:0]  ch_i,
    input  wire [15:0] mv_i,
    // sample port
    input  wire        ready_i,
    output reg         valid_o = 1'b0,
    output reg  [2:0]  ch_o = 3'h0,
    output reg  [15:0] mv_o = 16'h0
);
    always @(posedge clk_i)
    begin
        if (rst_i)
            valid_o <= 1'b0;
        else if (valid_o && ready_i)
        begin
            // released lines turn over so a stale reading cannot pass for a fresh one
            valid_o <= 1'b0;
            ch_o    <= ~ch_o;
            mv_o    <= ~mv_o;
        end
        else if (go_i && !valid_o)
        begin
            valid_o <= 1'b1;
            ch_o    <= ch_i;
            mv_o    <= mv_i;
        end
    end
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the universal input conditioner
`timescale 1ns/1ns
`include "uic_map.vh"
module tb_top;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [31:0] adr_i = 32'h0;
    reg  [31:0] dat_i = 32'h0;
    reg  [3:0]  sel_i = 4'h0;
    reg         we_i  = 1'b0;
    reg         cyc_i = 1'b0;
    reg         stb_i = 1'b0;
    reg         go    = 1'b0;
    reg  [2:0]  go_ch = 3'h0;
    reg  [15:0] go_mv = 16'h0;
    wire [31:0] dat_o;
    wire        ack_o;
    wire        sample_valid_i;
    wire        sample_ready_o;
    wire        par_wr_o;
    wire        par_level_o;
    wire        fast_ref_wr_o;
    wire [2:0]  sample_ch_i;
    wire [15:0] sample_mv_i;
    wire [15:0] par_val_o;
    wire [15:0] fast_ref_o;
    wire [9:0]  par_idx_o;
    wire [7:0]  logic_state_o;
    integer     err_total = 0;
    integer     compares  = 0;
    reg  [5:0]  nwr = 6'h0;
    reg  [5:0]  b;
    reg  [9:0]  wr_idx [0:63];
    reg  [15:0] wr_val [0:63];
    reg  [31:0] rd;

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        if (par_wr_o)
        begin
            wr_idx[nwr] <= par_idx_o;
            wr_val[nwr] <= par_val_o;
            nwr         <= nwr + 6'h1;
        end
    end

    universal_input_conditioner u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .sample_valid_i(sample_valid_i),
        .sample_ch_i(sample_ch_i), .sample_mv_i(sample_mv_i), .sample_ready_o(sample_ready_o),
        .par_wr_o(par_wr_o), .par_idx_o(par_idx_o), .par_val_o(par_val_o), .par_level_o(par_level_o),
        .fast_ref_wr_o(fast_ref_wr_o), .fast_ref_o(fast_ref_o), .logic_state_o(logic_state_o)
    );

    sampler_model u_sampler (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .ch_i(go_ch), .mv_i(go_mv), .ready_i(sample_ready_o),
        .valid_o(sample_valid_i), .ch_o(sample_ch_i), .mv_o(sample_mv_i)
    );

    task tally_and_finish;
    begin
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    task check(input [8*12-1:0] nm, input [31:0] exp, input [31:0] got);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("Error %0s expected %h seen %h", nm, exp, got);
        end
    end
    endtask

    task wb(input w, input [31:0] a, input [15:0] d, input [3:0] s);
        integer k;
    begin
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {16'h0, d};
        sel_i <= s;
        k = 0;
        @(posedge clk_i);
        while (!ack_o && k < 400)
        begin
            @(posedge clk_i);
            k = k + 1;
        end
        if (!ack_o)
        begin
            err_total = err_total + 1;
            tally_and_finish;
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    end
    endtask

    task cfg(input [2:0] ch, input [3:0] f, input [15:0] v);
        wb(1'b1, {22'h0, ch, f, 2'b00}, v, 4'hf);
    endtask

    task rchk(input [8*12-1:0] nm, input [2:0] ch, input [3:0] f, input [15:0] exp);
    begin
        wb(1'b0, {22'h0, ch, f, 2'b00}, 16'h0, 4'hf);
        check(nm, {16'h0, exp}, rd);
    end
    endtask

    // offers one reading and waits for the channel to go busy and come back idle
    task smp(input [2:0] ch, input [15:0] mv);
        integer k;
        reg     seen;
    begin
        b = nwr;
        seen = 1'b0;
        @(posedge clk_i);
        go    <= 1'b1;
        go_ch <= ch;
        go_mv <= mv;
        @(posedge clk_i);
        go <= 1'b0;
        for (k = 0; k < 60 && !(seen && sample_ready_o); k = k + 1)
        begin
            @(posedge clk_i);
            #1;
            if (!sample_ready_o)
                seen = 1'b1;
        end
        if (!(seen && sample_ready_o))
        begin
            err_total = err_total + 1;
            tally_and_finish;
        end
        // the slot 2 write is logged one edge after ready returns
        @(posedge clk_i);
        #1;
    end
    endtask

    task wchk(input [5:0] n, input [9:0] idx, input [15:0] val);
    begin
        check("write idx", {22'h0, idx}, {22'h0, wr_idx[b + n]});
        check("write val", {16'h0, val}, {16'h0, wr_val[b + n]});
    end
    endtask

    task t_reset_values;
    begin
        rchk("lin dest 2", 3'h0, `F_DEST_LIN, 16'h003f);
        rchk("lin dest 4", 3'h2, `F_DEST_LIN, 16'h001a);
        rchk("lin dest 3", 3'h1, `F_DEST_LIN, 16'h0190);
        rchk("out1 dest 9", 3'h7, `F_DEST1, 16'h0031);
        rchk("out1 dest 2", 3'h0, `F_DEST1, 16'h0190);
        rchk("out2 dest 5", 3'h3, `F_DEST2, 16'h0190);
        rchk("high out1", 3'h0, `F_HI1, 16'h0001);
        rchk("range", 3'h4, `F_RANGE, 16'h0001);
    end
    endtask

    task t_linear;
    begin
        cfg(3'h0, `F_OFFSET, 16'h0064);
        cfg(3'h0, `F_SCALE, 16'h4e20);
        smp(3'h0, 16'h0bb8);
        wchk(6'h0, 10'h03f, 16'h1838);
        check("write count", 32'h1, {26'h0, nwr - b});
        smp(3'h0, 16'h1770);
        wchk(6'h0, 10'h03f, 16'h2710);
        cfg(3'h0, `F_CLMIN, 16'hfe0c);
        cfg(3'h0, `F_SCALE, 16'hd8f0);
        smp(3'h0, 16'h07d0);
        wchk(6'h0, 10'h03f, 16'hfe0c);
        cfg(3'h0, `F_RANGE, 16'h0003);
        cfg(3'h0, `F_OFFSET, 16'h07d0);
        cfg(3'h0, `F_SCALE, 16'h2710);
        smp(3'h0, 16'h32c8);
        wchk(6'h0, 10'h03f, 16'h1388);
        cfg(3'h0, `F_RANGE, 16'h0000);
        smp(3'h0, 16'h03e8);
        wchk(6'h0, 10'h03f, 16'h1770);
        cfg(3'h0, `F_RANGE, 16'h0002);
        smp(3'h0, 16'h0fa0);
        wchk(6'h0, 10'h03f, 16'h0bb8);
    end
    endtask

    task t_logic;
    begin
        cfg(3'h6, `F_DEST2, 16'h0065);
        cfg(3'h6, `F_HI1, 16'h01f4);
        cfg(3'h6, `F_HI2, 16'hfff9);
        cfg(3'h6, `F_LO2, 16'h0003);
        cfg(3'h6, `F_THRESH, 16'hfc18);
        cfg(3'h6, `F_OFFSET, 16'hd8f0);
        cfg(3'h6, `F_SCALE, 16'h8ad0);
        smp(3'h6, 16'hfc19);
        check("state 8", 32'h1, {31'h0, logic_state_o[6]});
        wchk(6'h0, 10'h030, 16'h01f4);
        wchk(6'h1, 10'h065, 16'hfff9);
        smp(3'h6, 16'hfc18);
        check("state 8", 32'h0, {31'h0, logic_state_o[6]});
        wchk(6'h0, 10'h030, 16'h0000);
        wchk(6'h1, 10'h065, 16'h0003);
        wb(1'b0, 32'h200, 16'h0, 4'hf);
        check("status", 32'h1, rd);
    end
    endtask

    task t_term3;
    begin
        smp(3'h1, 16'h1388);
        check("fast ref", 32'h1388, {16'h0, fast_ref_o});
        check("write count", 32'h0, {26'h0, nwr - b});
        cfg(3'h1, `F_DEST_LIN, 16'h00c8);
        smp(3'h1, 16'hf63c);
        check("fast ref", 32'hf63c, {16'h0, fast_ref_o});
        wchk(6'h0, 10'h0c8, 16'hf63c);
    end
    endtask

    task t_refused;
    begin
        cfg(3'h2, `F_DEST2, 16'h03ff);
        rchk("dest limit", 3'h2, `F_DEST2, 16'h02d0);
        cfg(3'h2, `F_HI1, 16'h7918);
        rchk("high limit", 3'h2, `F_HI1, 16'h7530);
        wb(1'b1, {22'h0, 3'h2, `F_HI1, 2'b00}, 16'h1234, 4'h1);
        rchk("part write", 3'h2, `F_HI1, 16'h7530);
        wb(1'b1, 32'h400, 16'h5555, 4'hf);
        wb(1'b0, 32'h400, 16'h0, 4'hf);
        check("unmapped", 32'h0, rd);
    end
    endtask

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values;
        t_linear;
        t_logic;
        t_term3;
        t_refused;
        tally_and_finish;
    end
endmodule
